// ==== core/apedd_core.sv ====
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "apedd_cfg.svh"
module apedd_core (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        vid_sd,
	input  wire logic        vid_prog,
	input  wire logic        vid_field,
	input  wire logic        vid_vanc_end,
	input  wire logic        vid_line_start,
	input  wire logic [10:0] vid_line,
	input  wire logic        anc_hdr,
	input  wire logic [7:0]  anc_did,
	input  wire logic [7:0]  anc_sdid,
	input  wire logic        anc_chroma,
	input  wire logic        anc_vanc,
	input  wire logic [10:0] anc_line,
	input  wire logic        anc_byte_v,
	input  wire logic [7:0]  anc_byte,
	output logic             del_v,
	output logic             del_pkt,
	input  wire logic        src_valid,
	input  wire logic [7:0]  src_byte,
	output logic             src_ready,
	output logic             ins_v,
	output logic             ins_first,
	output logic             ins_end,
	output logic             ins_luma,
	output logic             ins_chroma,
	output logic      [7:0]  ins_did,
	output logic      [7:0]  ins_sdid,
	output logic      [7:0]  ins_byte,
	output logic             dec_v,
	output logic      [1:0]  dec_svc,
	output logic             dec_port,
	output logic      [7:0]  dec_byte
);
	// -----------------------------------------------------------
	// State
	// -----------------------------------------------------------
	typedef struct packed {
		logic [31:0]          enc_cfg;
		logic [31:0]          enc_cnt;
		logic [31:0]          enc_pfx;
		logic [31:0]          ovr;
		logic [31:0]          del_y;
		logic [31:0]          del_c;
		logic [3:0][18:0]     dec;
		logic [31:0]          prdata;
		logic                 pready;
		logic                 pslverr;
		apedd_pkg::apedd_enc_t st;
		logic [2:0]           pi;
		logic [7:0]           bcnt;
		logic                 fst;
		logic                 prio_local;
		logic                 seen;
		logic [7:0]           absent;
		logic                 del_v;
		logic                 del_pkt;
		logic                 ins_v;
		logic                 ins_first;
		logic                 ins_end;
		logic                 ins_luma;
		logic                 ins_chroma;
		logic [7:0]           ins_byte;
		logic                 hit;
		logic [1:0]           svc;
		logic [3:0]           mpend;
		logic                 tog;
		logic                 mfld;
		logic                 dec_v;
		logic                 dec_port;
		logic                 o_mark;
		logic [1:0]           dec_svc;
		logic [7:0]           dec_byte;
	} apedd_core_st_t;

	apedd_core_st_t r_reg;
	apedd_core_st_t r_next;

	// -----------------------------------------------------------
	// Source FIFO
	// -----------------------------------------------------------
	apedd_stream_if #(.W(`APEDD_FIFO_W)) w_if ();
	apedd_stream_if #(.W(`APEDD_FIFO_W)) r_if ();

	apedd_fifo #(
		.W     (`APEDD_FIFO_W),
		.DEPTH (`APEDD_FIFO_D)
	) u_fifo (
		.clk   (pclk),
		.rst_n (presetn),
		.wr    (w_if.snk),
		.rd    (r_if.src)
	);

	logic take;

	// Source side, stalls when the FIFO is full
	assign w_if.valid = src_valid;
	assign w_if.data  = src_byte;
	assign src_ready  = w_if.ready;
	assign r_if.ready = take;

	// -----------------------------------------------------------
	// Helpers
	// -----------------------------------------------------------
	function automatic logic lbit(input logic [31:0] m,
		input logic [10:0] ln);
		return (ln < 11'h020) && m[ln[4:0]];
	endfunction

	logic [7:0]  e_did;
	logic [7:0]  e_sdid;
	logic [10:0] e_line;
	logic        e_en;
	logic        prio_en;
	logic [7:0]  dc;
	logic [2:0]  plen;
	logic [7:0]  tmo;
	logic        ins_ok;
	logic        e_match;
	logic        ldel;
	logic        trig;
	logic        frame_tick;
	logic        setup;
	logic        acc;
	logic [5:0]  idx;

	assign e_did   = r_reg.enc_cfg[7:0];
	assign e_sdid  = r_reg.enc_cfg[`APEDD_SDID_LSB +: 8];
	assign e_line  = r_reg.enc_cfg[`APEDD_LINE_LSB +: 11];
	assign e_en    = r_reg.enc_cfg[`APEDD_EN_BIT];
	assign prio_en = r_reg.enc_cfg[`APEDD_PRIO_BIT];
	assign dc      = r_reg.enc_cnt[7:0];
	assign tmo     = r_reg.enc_cnt[`APEDD_TMO_LSB +: 8];
	assign plen    = (r_reg.enc_cnt[`APEDD_PLEN_LSB +: 3] > `APEDD_PFX_MAX)
		? `APEDD_PFX_MAX : r_reg.enc_cnt[`APEDD_PLEN_LSB +: 3];
	assign ins_ok  = !prio_en || r_reg.prio_local;
	assign setup   = psel && !penable;
	assign acc     = psel && penable;
	assign idx     = paddr[7:2];

	// Packet classification
	assign e_match = (anc_did == e_did) && (anc_sdid == e_sdid);
	assign ldel    = anc_vanc
		&& lbit(anc_chroma ? r_reg.del_c : r_reg.del_y, anc_line);
	assign frame_tick = vid_vanc_end && (vid_prog || vid_field);
	assign trig    = vid_line_start && (vid_line == e_line) && e_en
		&& (dc != 8'h00) && r_if.valid && ins_ok;

	// -----------------------------------------------------------
	// Next state
	// -----------------------------------------------------------
	always_comb
	begin
		r_next = r_reg;
		take   = 1'b0;

		// APB: zero wait, data and error staged in setup
		r_next.pready  = 1'b1;
		r_next.pslverr = setup && !((idx < 6'h06)
			|| ((idx >= 6'h08) && (idx <= 6'h0C)));
		if (setup)
		begin
			r_next.prdata = 32'h0000_0000;
			unique case (paddr)
				`APEDD_ENC_CFG:  r_next.prdata = r_reg.enc_cfg;
				`APEDD_ENC_CNT:  r_next.prdata = r_reg.enc_cnt;
				`APEDD_ENC_PFX:  r_next.prdata = r_reg.enc_pfx;
				`APEDD_OVR_MASK: r_next.prdata = r_reg.ovr;
				`APEDD_DEL_Y:    r_next.prdata = r_reg.del_y;
				`APEDD_DEL_C:    r_next.prdata = r_reg.del_c;
				`APEDD_STATUS:   r_next.prdata = {22'h000000, r_if.valid,
					r_reg.prio_local, r_reg.absent};
				default:
					if ((idx >= 6'h08) && (idx <= 6'h0B))
						r_next.prdata = {13'h0000,
							r_reg.dec[idx[1:0]]};
			endcase
		end
		if (acc && pwrite)
		begin
			unique case (paddr)
				`APEDD_ENC_CFG:  r_next.enc_cfg = pwdata;
				`APEDD_ENC_CNT:  r_next.enc_cnt = pwdata;
				`APEDD_ENC_PFX:  r_next.enc_pfx = pwdata;
				`APEDD_OVR_MASK: r_next.ovr     = pwdata;
				`APEDD_DEL_Y:    r_next.del_y   = pwdata;
				`APEDD_DEL_C:    r_next.del_c   = pwdata;
				default:
					if ((idx >= 6'h08) && (idx <= 6'h0B))
						r_next.dec[idx[1:0]] = pwdata[18:0];
			endcase
		end

		// Upstream priority: deleted lines are invisible
		if (frame_tick)
		begin
			if (r_reg.seen)
			begin
				r_next.absent     = 8'h00;
				r_next.prio_local = 1'b0;
			end
			else
			begin
				if (r_reg.absent != 8'hFF)
					r_next.absent = r_reg.absent + 8'h01;
				if ((9'(r_reg.absent) + 9'h001) >= 9'(tmo))
					r_next.prio_local = 1'b1;
			end
			r_next.seen = 1'b0;
		end
		if (anc_hdr && anc_vanc && e_match && !ldel)
			r_next.seen = 1'b1;

		// Deletion verdict, one cycle after each header
		r_next.del_v   = anc_hdr;
		r_next.del_pkt = anc_hdr && (ldel
			|| (anc_vanc && e_en && e_match && ins_ok
			&& lbit(r_reg.ovr, anc_line)));

		// Encoder sequencer
		r_next.ins_v     = 1'b0;
		r_next.ins_first = 1'b0;
		r_next.ins_end   = 1'b0;
		unique case (r_reg.st)
			apedd_pkg::ENC_IDLE:
				if (trig)
				begin
					r_next.ins_luma   = 1'b1;
					r_next.ins_chroma = vid_sd;
					r_next.bcnt       = 8'h00;
					r_next.pi         = 3'h0;
					r_next.fst        = 1'b1;
					r_next.st = (plen != 3'h0) ? apedd_pkg::ENC_PFX
						: apedd_pkg::ENC_DATA;
				end
			apedd_pkg::ENC_PFX:
			begin
				r_next.ins_v     = 1'b1;
				r_next.ins_first = r_reg.fst;
				r_next.fst       = 1'b0;
				r_next.ins_byte  =
					r_reg.enc_pfx[{r_reg.pi[1:0], 3'b000} +: 8];
				r_next.pi = r_reg.pi + 3'h1;
				if ((r_reg.pi + 3'h1) == plen)
					r_next.st = apedd_pkg::ENC_DATA;
			end
			apedd_pkg::ENC_DATA:
			begin
				take = r_if.valid && (r_reg.bcnt < dc);
				if (take)
				begin
					r_next.ins_v     = 1'b1;
					r_next.ins_first = r_reg.fst;
					r_next.fst       = 1'b0;
					r_next.ins_byte  = r_if.data;
					r_next.bcnt      = r_reg.bcnt + 8'h01;
				end
				else
				begin
					r_next.ins_end = 1'b1;
					r_next.st      = apedd_pkg::ENC_IDLE;
				end
			end
			default:
				r_next.st = apedd_pkg::ENC_IDLE;
		endcase

		// Decoder match, lowest service wins
		if (anc_hdr)
		begin
			r_next.hit = 1'b0;
			for (int i = 3; i >= 0; i--)
				if (r_reg.dec[i][`APEDD_DEC_EN]
					&& (r_reg.dec[i][7:0] == anc_did)
					&& (r_reg.dec[i][15:8] == anc_sdid))
				begin
					r_next.hit = 1'b1;
					r_next.svc = 2'(i);
				end
		end

		// Decoder output: packet bytes first, then markers
		r_next.dec_v  = 1'b0;
		r_next.o_mark = 1'b0;
		if (anc_byte_v && r_reg.hit
			&& r_reg.dec[r_reg.svc][`APEDD_DEC_EN])
		begin
			r_next.dec_v    = 1'b1;
			r_next.dec_byte = anc_byte;
			r_next.dec_svc  = r_reg.svc;
			r_next.dec_port = r_reg.dec[r_reg.svc][`APEDD_DEC_PORT];
		end
		else if (r_reg.mpend != 4'h0)
		begin
			for (int i = 3; i >= 0; i--)
				if (r_reg.mpend[i])
				begin
					r_next.dec_svc  = 2'(i);
					r_next.dec_port = r_reg.dec[i][`APEDD_DEC_PORT];
				end
			r_next.mpend[r_next.dec_svc] = 1'b0;
			r_next.dec_v    = 1'b1;
			r_next.o_mark   = 1'b1;
			r_next.dec_byte = r_reg.mfld ? `APEDD_FLD2
				: `APEDD_FLD1;
		end

		// Field markers queued at end of each vertical interval
		if (vid_vanc_end)
		begin
			for (int i = 0; i < 4; i++)
				if (r_reg.dec[i][`APEDD_DEC_EN]
					&& r_reg.dec[i][`APEDD_DEC_MARK])
					r_next.mpend[i] = 1'b1;
			r_next.mfld = vid_prog ? r_reg.tog : vid_field;
			r_next.tog  = vid_prog ? !r_reg.tog : 1'b0;
		end
	end

	// -----------------------------------------------------------
	// Registers
	// -----------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r_reg         <= '0;
			r_reg.pready  <= 1'b1;
			r_reg.enc_cnt <= `APEDD_CNT_RST;
		end
		else
			r_reg <= r_next;
	end

	// Outputs straight from state
	assign prdata     = r_reg.prdata;
	assign pready     = r_reg.pready;
	assign pslverr    = r_reg.pslverr;
	assign del_v      = r_reg.del_v;
	assign del_pkt    = r_reg.del_pkt;
	assign ins_v      = r_reg.ins_v;
	assign ins_first  = r_reg.ins_first;
	assign ins_end    = r_reg.ins_end;
	assign ins_luma   = r_reg.ins_luma;
	assign ins_chroma = r_reg.ins_chroma;
	assign ins_did    = r_reg.enc_cfg[7:0];
	assign ins_sdid   = r_reg.enc_cfg[`APEDD_SDID_LSB +: 8];
	assign ins_byte   = r_reg.ins_byte;
	assign dec_v      = r_reg.dec_v;
	assign dec_svc    = r_reg.dec_svc;
	assign dec_port   = r_reg.dec_port;
	assign dec_byte   = r_reg.dec_byte;

	// -----------------------------------------------------------
	// Checks
	// -----------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Bytes since packet start
	logic [8:0] hcnt;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			hcnt <= 9'h000;
		else if (r_next.ins_first)
			hcnt <= 9'h001;
		else if (r_next.ins_v)
			hcnt <= hcnt + 9'h001;
	end

	a_hanc_pass: assert property (anc_hdr && !anc_vanc
		|=> del_v && !del_pkt) else $error("HANC packet deleted");
	a_line_delete: assert property (anc_hdr && anc_vanc
		&& !anc_chroma && lbit(r_reg.del_y, anc_line) |=> del_pkt)
		else $error("selected luma line not deleted");
	a_sd_chroma: assert property (r_reg.st == apedd_pkg::ENC_IDLE
		&& trig |=> ins_luma && ins_chroma == $past(vid_sd))
		else $error("insert channel wrong for format");
	a_byte_limit: assert property (ins_v
		|-> hcnt <= 9'(dc) + 9'(plen))
		else $error("line byte count exceeded");
	a_prefix_first: assert property (ins_v && ins_first
		&& plen != 3'h0 |-> ins_byte == r_reg.enc_pfx[7:0])
		else $error("packet does not start with prefix");
	a_prio_timeout: assert property ($rose(r_reg.prio_local)
		|-> 9'($past(r_reg.absent)) + 9'h001 >= 9'($past(tmo)))
		else $error("priority switched before timeout");
	a_dec_forward: assert property (anc_byte_v && r_reg.hit
		&& r_reg.dec[r_reg.svc][`APEDD_DEC_EN]
		|=> dec_v && !r_reg.o_mark && dec_byte == $past(anc_byte))
		else $error("matched byte not forwarded");
	a_mark_char: assert property (r_reg.o_mark |-> dec_v
		&& (dec_byte == `APEDD_FLD1 || dec_byte == `APEDD_FLD2))
		else $error("bad field marker byte");

	c_insert: cover property (ins_first ##[1:300] ins_end);
	c_delete: cover property (del_v && del_pkt);
	c_marker: cover property (r_reg.o_mark);
	c_prio: cover property ($rose(r_reg.prio_local));
endmodule

// ==== include/apedd_cfg.svh ====
`ifndef APEDD_CFG_SVH
`define APEDD_CFG_SVH
// -----------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------
`define APEDD_ENC_CFG  8'h00
`define APEDD_ENC_CNT  8'h04
`define APEDD_ENC_PFX  8'h08
`define APEDD_OVR_MASK 8'h0C
`define APEDD_DEL_Y    8'h10
`define APEDD_DEL_C    8'h14
`define APEDD_DEC0     8'h20
`define APEDD_DEC3     8'h2C
`define APEDD_STATUS   8'h30
// -----------------------------------------------------------
// Field positions
// -----------------------------------------------------------
`define APEDD_SDID_LSB 8
`define APEDD_LINE_LSB 16
`define APEDD_EN_BIT   27
`define APEDD_PRIO_BIT 28
`define APEDD_PLEN_LSB 8
`define APEDD_TMO_LSB  16
`define APEDD_DEC_EN   16
`define APEDD_DEC_MARK 17
`define APEDD_DEC_PORT 18
// -----------------------------------------------------------
// Reset values and constants
// -----------------------------------------------------------
`define APEDD_CNT_RST  32'h0003_00FF
`define APEDD_PFX_MAX  3'h4
`define APEDD_FLD1     8'h31
`define APEDD_FLD2     8'h32
`define APEDD_FIFO_W   8
`define APEDD_FIFO_D   16
`endif

// ==== include/apedd_pkg.sv ====
package apedd_pkg;
	// Encoder packet sequencer states
	typedef enum logic [1:0]
	{
		ENC_IDLE = 2'b00,
		ENC_PFX  = 2'b01,
		ENC_DATA = 2'b10
	} apedd_enc_t;
endpackage

// ==== include/apedd_stream_if.sv ====
`timescale 1ns/10ps
interface apedd_stream_if #(parameter int W = 8);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ==== core/apedd_fifo.sv ====
`timescale 1ns/10ps
module apedd_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 16,
	parameter int AW    = $clog2(DEPTH)
) (
	input wire logic    clk,
	input wire logic    rst_n,
	apedd_stream_if.snk wr,
	apedd_stream_if.src rd
);
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
		logic          rdy;
	} apedd_fifo_st_t;

	apedd_fifo_st_t r_reg;
	apedd_fifo_st_t r_next;
	logic [W-1:0]   mem [DEPTH];
	logic           push;
	logic           pop;

	// Handshakes, ready is a flop so back-pressure is clean
	assign push     = wr.valid && r_reg.rdy;
	assign pop      = rd.valid && rd.ready;
	assign wr.ready = r_reg.rdy;
	assign rd.valid = (r_reg.cnt != '0);
	assign rd.data  = mem[r_reg.rp];

	// Pointer and level update
	always_comb
	begin
		r_next = r_reg;
		if (push)
			r_next.wp = r_reg.wp + 1'b1;
		if (pop)
			r_next.rp = r_reg.rp + 1'b1;
		r_next.cnt = r_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
		r_next.rdy = (r_next.cnt != (AW+1)'(DEPTH));
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			r_reg     <= '0;
			r_reg.rdy <= 1'b1;
		end
		else
			r_reg <= r_next;
	end

	// Storage write
	always_ff @(posedge clk)
	begin
		if (push)
			mem[r_reg.wp] <= wr.data;
	end

	a_full_stall: assert property (@(posedge clk) disable iff (!rst_n)
		r_reg.cnt == (AW+1)'(DEPTH) |-> !wr.ready)
		else $error("fifo full but source not stalled");
	c_fifo_full: cover property (@(posedge clk) disable iff (!rst_n)
		!wr.ready);
endmodule

// ==== verification/apedd_src_model.sv ====
`timescale 1ns/10ps
// ---------------------------------------------------------
// Byte source on the host side of the encoder data port
// ---------------------------------------------------------
module apedd_src_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       src_ready,
	input  wire logic [7:0] n_goal,
	output logic            src_valid,
	output logic      [7:0] src_byte,
	output logic      [7:0] n_sent
);
	logic [7:0] nxt;

	// Count of bytes taken once this edge completes
	assign nxt = n_sent + {7'h00, src_valid & src_ready};

	// Offer bytes 0x50 upward, held until taken
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			src_valid <= 1'b0;
			src_byte  <= 8'h00;
			n_sent    <= 8'h00;
		end
		else
		begin
			n_sent <= nxt;
			if (nxt < n_goal)
			begin
				src_valid <= 1'b1;
				src_byte  <= 8'h50 + nxt;
			end
			else
			begin
				src_valid <= 1'b0;
				src_byte  <= ~src_byte; // Released: no stale value
			end
		end
	end
endmodule

// ==== verification/testbench.sv ====
`timescale 1ns/10ps
`include "apedd_cfg.svh"
module testbench;
	typedef struct packed
	{
		logic [7:0]  did;
		logic [7:0]  sdid;
		logic        ch;
		logic        vanc;
		logic [10:0] line;
		logic        del;
		logic        hit;
		logic [1:0]  svc;
		logic        port;
	} apedd_row_t;
	// ---------------------------------------------------------
	// Signals
	// ---------------------------------------------------------
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic        vid_sd = 1'b0;
	logic        vid_prog = 1'b0;
	logic        vid_field = 1'b0;
	logic        vid_vanc_end = 1'b0;
	logic        vid_line_start = 1'b0;
	logic [10:0] vid_line = 11'h000;
	logic        anc_hdr = 1'b0;
	logic [7:0]  anc_did = 8'h00;
	logic [7:0]  anc_sdid = 8'h00;
	logic        anc_chroma = 1'b0;
	logic        anc_vanc = 1'b0;
	logic [10:0] anc_line = 11'h000;
	logic        anc_byte_v = 1'b0;
	logic [7:0]  anc_byte = 8'h00;
	logic [7:0]  n_goal = 8'h00;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, err, del_v, del_pkt;
	logic        src_valid, src_ready, ins_v, ins_first, ins_end;
	logic        ins_luma, ins_chroma, dec_v, dec_port;
	logic [7:0]  src_byte, ins_did, ins_sdid, ins_byte, dec_byte;
	logic [7:0]  n_sent;
	logic [1:0]  dec_svc;
	int          n_mismatch = 0;
	int          n_checks = 0;
	apedd_row_t  rows [12] = '{
		'{8'h61, 8'h01, 1'h0, 1'h1, 11'h00C, 1'h1, 1'h0, 2'h0, 1'h0},
		'{8'h61, 8'h01, 1'h0, 1'h0, 11'h00C, 1'h0, 1'h0, 2'h0, 1'h0},
		'{8'h61, 8'h01, 1'h0, 1'h1, 11'h00D, 1'h0, 1'h0, 2'h0, 1'h0},
		'{8'h10, 8'h06, 1'h0, 1'h1, 11'h009, 1'h1, 1'h0, 2'h0, 1'h0},
		'{8'h10, 8'h06, 1'h1, 1'h1, 11'h009, 1'h0, 1'h0, 2'h0, 1'h0},
		'{8'h10, 8'h06, 1'h1, 1'h1, 11'h00A, 1'h1, 1'h0, 2'h0, 1'h0},
		'{8'h41, 8'h07, 1'h1, 1'h0, 11'h005, 1'h0, 1'h1, 2'h0, 1'h0},
		'{8'h60, 8'h60, 1'h0, 1'h1, 11'h014, 1'h0, 1'h1, 2'h1, 1'h1},
		'{8'h41, 8'h01, 1'h1, 1'h1, 11'h003, 1'h0, 1'h1, 2'h2, 1'h0},
		'{8'h23, 8'h45, 1'h0, 1'h0, 11'h258, 1'h0, 1'h1, 2'h3, 1'h1},
		'{8'h41, 8'h45, 1'h0, 1'h1, 11'h014, 1'h0, 1'h0, 2'h0, 1'h0},
		'{8'h61, 8'h01, 1'h0, 1'h1, 11'h009, 1'h1, 1'h0, 2'h0, 1'h0}};

	// Clock
	always #10 pclk = ~pclk;

	apedd_core apedd_core_i (.pclk, .presetn, .paddr, .psel, .penable,
		.pwrite, .pwdata, .prdata, .pready, .pslverr, .vid_sd, .vid_prog,
		.vid_field, .vid_vanc_end, .vid_line_start, .vid_line, .anc_hdr,
		.anc_did, .anc_sdid, .anc_chroma, .anc_vanc, .anc_line,
		.anc_byte_v, .anc_byte, .del_v, .del_pkt, .src_valid, .src_byte,
		.src_ready, .ins_v, .ins_first, .ins_end, .ins_luma, .ins_chroma,
		.ins_did, .ins_sdid, .ins_byte, .dec_v, .dec_svc, .dec_port,
		.dec_byte);
	apedd_src_model apedd_src_model_i (.pclk, .presetn, .src_ready,
		.n_goal, .src_valid, .src_byte, .n_sent);

	// ---------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------
	task tally_and_finish;
		$display("Checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask

	task hang;
		n_mismatch++;
		tally_and_finish;
	endtask

	// APB transfer, result in rd and err
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
			if (k > 20)
				hang;
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Header plus one body byte, verdict and forwarding
	task hdr(input apedd_row_t r);
		@(posedge pclk);
		anc_hdr <= 1'b1;
		{anc_did, anc_sdid} <= {r.did, r.sdid};
		{anc_chroma, anc_vanc} <= {r.ch, r.vanc};
		anc_line <= r.line;
		@(posedge pclk);
		anc_hdr <= 1'b0;
		anc_byte_v <= 1'b1;
		anc_byte <= r.did ^ 8'h5A;
		@(negedge pclk);
		chk("del_v", del_v, 1);
		chk("del_pkt", del_pkt, r.del);
		@(posedge pclk);
		anc_byte_v <= 1'b0;
		@(negedge pclk);
		chk("dec_v", dec_v, r.hit);
		if (r.hit)
		begin
			chk("dec_byte", dec_byte, r.did ^ 8'h5A);
			chk("dec_svc", dec_svc, r.svc);
			chk("dec_port", dec_port, r.port);
		end
	endtask

	task frame;
		@(posedge pclk);
		vid_vanc_end <= 1'b1;
		@(posedge pclk);
		vid_vanc_end <= 1'b0;
	endtask

	task dec_wait(input logic [7:0] b, input logic [1:0] s);
		int t;
		t = 0;
		do
		begin
			@(negedge pclk);
			t++;
			if (t > 20)
				hang;
		end while (dec_v !== 1'b1);
		chk("marker", dec_byte, b);
		chk("marker_svc", {dec_svc, dec_port}, {s, 1'b1});
	endtask

	// Trigger on line 12 and collect one inserted packet
	task ins_chk(input int pfx, input int n, input logic [7:0] b0,
		input logic ch);
		int k, t;
		logic [7:0] e;
		@(posedge pclk);
		vid_line <= 11'h00C;
		vid_line_start <= 1'b1;
		@(posedge pclk);
		vid_line_start <= 1'b0;
		k = 0;
		for (t = 0; ins_end !== 1'b1; t++)
		begin
			if (t > 60)
				hang;
			@(negedge pclk);
			e = (k == 0) ? 8'hFA : 8'hAF;
			if (k >= pfx)
				e = b0 + 8'(k - pfx);
			if (ins_v === 1'b1)
			begin
				chk("ins_byte", ins_byte, e);
				chk("ins_first", ins_first, k == 0);
				k++;
			end
		end
		chk("ins_count", k, n);
		chk("ins_chan", {ins_luma, ins_chroma}, {1'b1, ch});
		chk("ins_ids", {ins_did, ins_sdid}, 16'h6101);
	endtask

	// ---------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------
	initial
	begin
		int i;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(`APEDD_ENC_CNT, 1'b0, 32'h0);
		chk("cnt_reset", rd, `APEDD_CNT_RST);
		apb(`APEDD_DEC0, 1'b0, 32'h0);
		chk("dec0_reset", rd, 32'h0);
		apb(8'h40, 1'b0, 32'h0);
		chk("unmapped_rd", rd, 32'h0);
		chk("unmapped_err", err, 1'b1);
		apb(`APEDD_ENC_CFG, 1'b1, 32'h080C_0161);
		apb(`APEDD_OVR_MASK, 1'b1, 32'h0000_1000);
		apb(`APEDD_DEL_Y, 1'b1, 32'h0000_0200);
		apb(`APEDD_DEL_C, 1'b1, 32'h0000_0400);
		apb(8'h20, 1'b1, 32'h0001_0741);
		apb(8'h24, 1'b1, 32'h0007_6060);
		apb(8'h28, 1'b1, 32'h0001_0141);
		apb(`APEDD_DEC3, 1'b1, 32'h0007_4523);
		for (i = 0; i < 12; i++)
			hdr(rows[i]);
		// Markers: progressive twice, then field two, field one
		for (i = 0; i < 4; i++)
		begin
			@(posedge pclk);
			vid_prog <= (i < 2);
			vid_field <= (i == 2);
			frame();
			dec_wait((i == 1 || i == 2) ? 8'h32 : 8'h31, 2'h1);
			dec_wait((i == 1 || i == 2) ? 8'h32 : 8'h31, 2'h3);
		end
		// Upstream seen, then absent frames against timeout 3
		hdr(rows[0]);
		@(posedge pclk);
		vid_prog <= 1'b1;
		apb(`APEDD_ENC_CFG, 1'b1, 32'h180C_0161);
		// First frame holds the upstream packet, two absent ones follow
		frame();
		frame();
		frame();
		apb(`APEDD_STATUS, 1'b0, 32'h0);
		chk("absent_2", rd[8:0], 9'h002);
		// Packet on a deleted line must not reset the absent count
		hdr(rows[11]);
		frame();
		apb(`APEDD_STATUS, 1'b0, 32'h0);
		chk("switched", rd[9:0], 10'h103);
		apb(`APEDD_ENC_CFG, 1'b1, 32'h080C_0161);
		// Fill the buffer until the source is held off
		n_goal <= 8'h14;
		for (i = 0; src_ready !== 1'b0; i++)
		begin
			if (i > 60)
				hang;
			@(posedge pclk);
		end
		repeat (4) @(posedge pclk);
		chk("held_off", {n_sent, src_ready}, {8'h10, 1'b0});
		apb(`APEDD_ENC_CNT, 1'b1, 32'h0003_0203);
		apb(`APEDD_ENC_PFX, 1'b1, 32'h0000_AFFA);
		ins_chk(2, 5, 8'h50, 1'b0);
		frame();
		vid_sd <= 1'b1;
		apb(`APEDD_ENC_CNT, 1'b1, 32'h0003_0010);
		ins_chk(0, 16, 8'h53, 1'b1);
		repeat (8) @(posedge pclk);
		chk("all_taken", n_sent, 8'h14);
		tally_and_finish;
	end
endmodule
